// [nab_pkg.sv]
// shared constants for the nand host sequencer
package nab_pkg;
  // clock period in ns
  localparam int CLK_NS = 4;
  // least pin cycle times, ns
  localparam int T_WP_NS = 25;
  localparam int T_WC_NS = 45;
  localparam int T_RC_NS = 50;
  localparam int T_REA_NS = 30;
  localparam int T_WB_NS = 100;
  localparam int T_WHR_NS = 60;
  // busy limits, us
  localparam int T_R_US = 25;
  localparam int T_RST_US = 500;
  localparam int T_PROG_US = 700;
  localparam int T_ERS_US = 3000;
  // least times rounded up to whole cycles
  localparam int WP_CYC = (T_WP_NS + CLK_NS - 1) / CLK_NS;
  localparam int WC_CYC = (T_WC_NS + CLK_NS - 1) / CLK_NS;
  localparam int RC_CYC = (T_RC_NS + CLK_NS - 1) / CLK_NS;
  localparam int REA_CYC = (T_REA_NS + CLK_NS - 1) / CLK_NS;
  localparam int WB_CYC = (T_WB_NS + CLK_NS - 1) / CLK_NS;
  localparam int WHR_CYC = (T_WHR_NS + CLK_NS - 1) / CLK_NS;
  localparam int TR_CYC = T_R_US * 1000 / CLK_NS;
  localparam int RST_CYC = T_RST_US * 1000 / CLK_NS;
  localparam int PROG_CYC = T_PROG_US * 1000 / CLK_NS;
  localparam int ERS_CYC = T_ERS_US * 1000 / CLK_NS;
  // page sizes including spare area
  localparam int PAGE_X8 = 2112;
  localparam int PAGE_X16 = 1056;
  // command codes
  localparam logic [7:0] C_READ1 = 8'h00;
  localparam logic [7:0] C_READ2 = 8'h30;
  localparam logic [7:0] C_PROG1 = 8'h80;
  localparam logic [7:0] C_PROG2 = 8'h10;
  localparam logic [7:0] C_ERS1 = 8'h60;
  localparam logic [7:0] C_ERS2 = 8'hd0;
  localparam logic [7:0] C_STAT = 8'h70;
  localparam logic [7:0] C_RST = 8'hff;
  // user operations
  typedef enum logic [2:0] {OP_RESET, OP_READ, OP_PROG, OP_ERASE, OP_STATUS} nab_op_e;
endpackage : nab_pkg

// [nab_fifo.sv]
// small synchronous fifo with valid/ready on both sides
module nab_fifo #(
  parameter int W = 16,
  parameter int D = 8
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // fill side
  input wire logic [W-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  // drain side
  output logic [W-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem_ff [D]; // storage, depth must be a power of two
  logic [AW:0] wp_ff, nxt_wp; // write pointer with wrap bit
  logic [AW:0] rp_ff, nxt_rp; // read pointer with wrap bit
  logic push, pop;

  // full when wrap bits differ and indices match
  always_comb begin
    in_ready = !((wp_ff[AW] != rp_ff[AW]) && (wp_ff[AW-1:0] == rp_ff[AW-1:0]));
    out_valid = (wp_ff != rp_ff);
    out_data = mem_ff[rp_ff[AW-1:0]];
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    nxt_wp = push ? wp_ff + 1'b1 : wp_ff;
    nxt_rp = pop ? rp_ff + 1'b1 : rp_ff;
  end

  // pointers reset, storage does not need it
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      wp_ff <= '0;
      rp_ff <= '0;
    end else begin
      wp_ff <= nxt_wp;
      rp_ff <= nxt_rp;
    end
    if (push) begin
      mem_ff[wp_ff[AW-1:0]] <= in_data;
    end
  end
endmodule : nab_fifo

// [nab_host.sv]
// host-side sequencer driving an asynchronous parallel nand flash
module nab_host import nab_pkg::*; #(
  parameter int TR_LIM = TR_CYC,
  parameter int RST_LIM = RST_CYC,
  parameter int PROG_LIM = PROG_CYC,
  parameter int ERS_LIM = ERS_CYC
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // command port
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic [2:0] cmd_op,
  input wire logic [11:0] cmd_col,
  input wire logic [15:0] cmd_row,
  input wire logic [11:0] cmd_len,
  input wire logic x16_mode,
  // program data in
  input wire logic [15:0] wr_data,
  input wire logic wr_valid,
  output logic wr_ready,
  // read data out
  output logic [15:0] rd_data,
  output logic rd_valid,
  input wire logic rd_ready,
  // completion
  output logic done,
  output logic fail,
  output logic timeout,
  // flash pins
  output logic ce_n,
  output logic cle,
  output logic ale,
  output logic we_n,
  output logic output_strobe_n,
  output logic wp_n,
  output logic [15:0] io_out,
  output logic io_oe,
  input wire logic [15:0] io_in,
  input wire logic rb_n
);
  typedef enum logic [3:0] {
    ST_IDLE, ST_CMD, ST_ADDR, ST_DIN, ST_CMD2, ST_WB, ST_BUSY, ST_WHR, ST_DOUT, ST_DONE
  } nab_st_e;

  nab_st_e st_ff, nxt_st; // sequencer state
  logic [4:0] cnt_ff, nxt_cnt; // cycle counter inside one pin cycle
  logic [19:0] tmr_ff, nxt_tmr; // busy watchdog
  logic [1:0] idx_ff, nxt_idx; // address cycle index
  logic [11:0] wcnt_ff, nxt_wcnt; // words moved so far
  logic [11:0] nw_ff, nxt_nw; // words in this sequence
  nab_op_e op_ff, nxt_op; // latched operation
  logic [11:0] col_ff, nxt_col; // column address
  logic [15:0] row_ff, nxt_row; // row address
  logic x16_ff, nxt_x16; // organisation of this sequence
  logic stat_ff, nxt_stat; // status read phase after busy
  logic cle_ff, nxt_cle, ale_ff, nxt_ale, we_ff, nxt_we, re_ff, nxt_re, ce_ff, nxt_ce;
  logic oe_ff, nxt_oe, wp_ff; // pin registers
  logic [15:0] io_ff, nxt_io; // driven data lines
  logic [15:0] rdat_ff, nxt_rdat; // captured read word
  logic rdv_ff, nxt_rdv, done_ff, nxt_done, fail_ff, nxt_fail, to_ff, nxt_to;
  logic [15:0] fifo_data; // fifo head word
  logic fifo_valid, fifo_pop;
  logic wend, rend; // last cycle of a write or read pin cycle
  logic [7:0] ccode, abyte; // command and address bytes
  logic [11:0] page, lim_len;
  int unsigned blim;

  // program data is staged here so the user may stall independently of the pins
  nab_fifo #(.W(16), .D(8)) u_fifo (
    .core_clk(core_clk),
    .nrst(nrst),
    .in_data(wr_data),
    .in_valid(wr_valid),
    .in_ready(wr_ready),
    .out_data(fifo_data),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop)
  );

  // command byte per phase
  always_comb begin
    ccode = C_STAT;
    if (st_ff == ST_CMD2) begin
      ccode = (op_ff == OP_READ) ? C_READ2 : (op_ff == OP_PROG) ? C_PROG2 : C_ERS2;
    end else if (!stat_ff) begin
      unique case (op_ff)
        OP_RESET: ccode = C_RST;
        OP_READ: ccode = C_READ1;
        OP_PROG: ccode = C_PROG1;
        // erase only when asked; keeping factory markers is up to firmware
        OP_ERASE: ccode = C_ERS1;
        default: ccode = C_STAT; // status and illegal codes
      endcase
    end
  end

  // address byte per cycle, column split depends on width
  always_comb begin
    unique case (idx_ff)
      2'd0: abyte = col_ff[7:0];
      2'd1: abyte = x16_ff ? {5'h00, col_ff[10:8]} : {4'h0, col_ff[11:8]};
      2'd2: abyte = row_ff[7:0];
      2'd3: abyte = row_ff[15:8];
    endcase
  end

  // busy limit follows the operation that made the device busy
  always_comb begin
    unique case (op_ff)
      OP_RESET: blim = RST_LIM;
      OP_READ: blim = TR_LIM;
      OP_PROG: blim = PROG_LIM;
      default: blim = ERS_LIM;
    endcase
  end

  // page length clamp, a zero length still moves one word
  always_comb begin
    page = x16_mode ? 12'(PAGE_X16) : 12'(PAGE_X8);
    lim_len = (cmd_len > page) ? page : cmd_len;
    if (lim_len == 12'h000) begin
      lim_len = 12'h001;
    end
  end

  assign wend = (cnt_ff == 5'(WC_CYC - 1));
  assign rend = (cnt_ff == 5'(RC_CYC - 1));
  assign fifo_pop = (st_ff == ST_DIN) && wend;

  // sequencer next state and pin values
  always_comb begin
    nxt_st = st_ff;
    nxt_cnt = cnt_ff + 5'h01;
    nxt_tmr = tmr_ff;
    nxt_idx = idx_ff;
    nxt_wcnt = wcnt_ff;
    nxt_nw = nw_ff;
    nxt_op = op_ff;
    nxt_col = col_ff;
    nxt_row = row_ff;
    nxt_x16 = x16_ff;
    nxt_stat = stat_ff;
    nxt_cle = 1'b0;
    nxt_ale = 1'b0;
    nxt_we = 1'b1;
    nxt_re = 1'b1;
    nxt_ce = 1'b1; // idle chip enable high saves standby power
    nxt_oe = 1'b0;
    nxt_io = io_ff;
    nxt_rdat = rdat_ff;
    nxt_rdv = 1'b0;
    nxt_done = 1'b0;
    nxt_fail = fail_ff;
    nxt_to = to_ff;
    unique case (st_ff)
      // accept one command, results stay until the next
      ST_IDLE: begin
        nxt_cnt = 5'h00;
        if (cmd_valid) begin
          nxt_op = nab_op_e'(cmd_op);
          nxt_col = cmd_col;
          nxt_row = cmd_row;
          nxt_x16 = x16_mode;
          nxt_nw = lim_len;
          nxt_stat = 1'b0;
          nxt_fail = 1'b0;
          nxt_to = 1'b0;
          nxt_wcnt = 12'h000;
          nxt_idx = (nab_op_e'(cmd_op) == OP_ERASE) ? 2'd2 : 2'd0; // erase sends rows only
          nxt_st = ST_CMD;
        end
      end
      // command latch cycle
      ST_CMD, ST_CMD2: begin
        nxt_ce = 1'b0;
        nxt_cle = 1'b1;
        nxt_oe = 1'b1;
        nxt_io = {8'h00, ccode};
        nxt_we = !(cnt_ff < 5'(WP_CYC));
        if (wend) begin
          nxt_cnt = 5'h00;
          if (st_ff == ST_CMD2 || op_ff == OP_RESET) begin
            nxt_st = ST_WB;
          end else if (stat_ff || op_ff == OP_STATUS) begin
            nxt_st = ST_WHR;
          end else begin
            nxt_st = ST_ADDR;
          end
        end
      end
      // address latch cycles
      ST_ADDR: begin
        nxt_ce = 1'b0;
        nxt_ale = 1'b1;
        nxt_oe = 1'b1;
        nxt_io = {8'h00, abyte};
        nxt_we = !(cnt_ff < 5'(WP_CYC));
        if (wend) begin
          nxt_cnt = 5'h00;
          nxt_idx = idx_ff + 2'd1;
          if (idx_ff == 2'd3) begin
            nxt_st = (op_ff == OP_PROG) ? ST_DIN : ST_CMD2;
          end
        end
      end
      // data loading, chip enable released while the fifo runs dry
      ST_DIN: begin
        if (cnt_ff == 5'h00 && !fifo_valid) begin
          nxt_cnt = 5'h00;
        end else begin
          nxt_ce = 1'b0;
          nxt_oe = 1'b1;
          nxt_io = x16_ff ? fifo_data : {8'h00, fifo_data[7:0]};
          nxt_we = !(cnt_ff < 5'(WP_CYC));
          if (wend) begin
            nxt_cnt = 5'h00;
            nxt_wcnt = wcnt_ff + 12'h001;
            if (wcnt_ff == nw_ff - 12'h001) begin
              nxt_st = ST_CMD2;
            end
          end
        end
      end
      // busy may take this long to appear after the last strobe
      ST_WB: begin
        nxt_tmr = 20'h00000;
        if (cnt_ff == 5'(WB_CYC - 1)) begin
          nxt_st = ST_BUSY;
        end
      end
      // hold off everything until ready, watchdog guards a stuck line
      ST_BUSY: begin
        nxt_cnt = 5'h00;
        nxt_tmr = tmr_ff + 20'h00001;
        if (rb_n) begin
          if (op_ff == OP_READ) begin
            nxt_st = ST_WHR;
          end else if (op_ff == OP_RESET) begin
            nxt_st = ST_DONE;
          end else begin
            nxt_stat = 1'b1;
            nxt_st = ST_CMD;
          end
        end else if (tmr_ff == 20'(blim)) begin
          nxt_to = 1'b1;
          nxt_fail = 1'b1;
          nxt_st = ST_DONE;
        end
      end
      // turnaround before the first read strobe
      ST_WHR: begin
        if (cnt_ff == 5'(WHR_CYC - 1)) begin
          nxt_cnt = 5'h00;
          nxt_wcnt = 12'h000;
          nxt_st = ST_DOUT;
        end
      end
      // serial read out, paused with chip enable high when the user stalls
      ST_DOUT: begin
        if (cnt_ff == 5'h00 && !rd_ready) begin
          nxt_cnt = 5'h00;
        end else begin
          nxt_ce = 1'b0;
          nxt_re = !(cnt_ff < 5'(REA_CYC));
          if (cnt_ff == 5'(REA_CYC)) begin
            // raw word handed up, single-bit correction is left to firmware
            nxt_rdat = x16_ff ? io_in : {8'h00, io_in[7:0]};
            nxt_rdv = 1'b1;
            if (stat_ff || op_ff == OP_STATUS) begin
              // flag tells firmware to retire and replace the block
              nxt_fail = io_in[0];
            end
          end
          if (rend) begin
            nxt_cnt = 5'h00;
            nxt_wcnt = wcnt_ff + 12'h001;
            if (stat_ff || op_ff == OP_STATUS || wcnt_ff == nw_ff - 12'h001) begin
              nxt_st = ST_DONE;
            end
          end
        end
      end
      // one-cycle completion pulse
      ST_DONE: begin
        nxt_done = 1'b1;
        nxt_st = ST_IDLE;
      end
      default: nxt_st = ST_IDLE;
    endcase
  end

  // register everything; write protect held active through reset
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      st_ff <= ST_IDLE;
      cnt_ff <= '0;
      tmr_ff <= '0;
      idx_ff <= '0;
      wcnt_ff <= '0;
      nw_ff <= '0;
      op_ff <= OP_RESET;
      col_ff <= '0;
      row_ff <= '0;
      x16_ff <= 1'b0;
      stat_ff <= 1'b0;
      cle_ff <= 1'b0;
      ale_ff <= 1'b0;
      we_ff <= 1'b1;
      re_ff <= 1'b1;
      ce_ff <= 1'b1;
      oe_ff <= 1'b0;
      wp_ff <= 1'b0;
      io_ff <= '0;
      rdat_ff <= '0;
      rdv_ff <= 1'b0;
      done_ff <= 1'b0;
      fail_ff <= 1'b0;
      to_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      cnt_ff <= nxt_cnt;
      tmr_ff <= nxt_tmr;
      idx_ff <= nxt_idx;
      wcnt_ff <= nxt_wcnt;
      nw_ff <= nxt_nw;
      op_ff <= nxt_op;
      col_ff <= nxt_col;
      row_ff <= nxt_row;
      x16_ff <= nxt_x16;
      stat_ff <= nxt_stat;
      cle_ff <= nxt_cle;
      ale_ff <= nxt_ale;
      we_ff <= nxt_we;
      re_ff <= nxt_re;
      ce_ff <= nxt_ce;
      oe_ff <= nxt_oe;
      wp_ff <= 1'b1;
      io_ff <= nxt_io;
      rdat_ff <= nxt_rdat;
      rdv_ff <= nxt_rdv;
      done_ff <= nxt_done;
      fail_ff <= nxt_fail;
      to_ff <= nxt_to;
    end
  end

  // outputs
  assign cmd_ready = (st_ff == ST_IDLE);
  assign rd_data = rdat_ff;
  assign rd_valid = rdv_ff;
  assign done = done_ff;
  assign fail = fail_ff;
  assign timeout = to_ff;
  assign ce_n = ce_ff;
  assign cle = cle_ff;
  assign ale = ale_ff;
  assign we_n = we_ff;
  assign output_strobe_n = re_ff;
  assign wp_n = wp_ff;
  assign io_out = io_ff;
  assign io_oe = oe_ff;
endmodule : nab_host

// [nab_host_checker.sv]
// concurrent checks on the pins of the nand host sequencer
module nab_host_checker (
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // user side
  input wire logic cmd_ready,
  input wire logic done,
  input wire logic rd_valid,
  input wire logic fail,
  input wire logic timeout,
  // flash pins
  input wire logic ce_n,
  input wire logic cle,
  input wire logic ale,
  input wire logic we_n,
  input wire logic output_strobe_n,
  input wire logic [15:0] io_out,
  input wire logic io_oe,
  input wire logic rb_n
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);
  // pins parked right after reset
  a_reset_pins_idle: assert property ($rose(nrst) |-> ce_n && we_n && !io_oe && !done)
    else $error("pins not idle after reset");
  a_cmd_upper_zero: assert property ((cle || ale) && io_oe |-> io_out[15:8] == 8'h00)
    else $error("upper data byte not zero on latch cycle");
  a_latch_exclusive: assert property (!(cle && ale))
    else $error("command and address latch both high");
  a_strobe_exclusive: assert property (!(!we_n && !output_strobe_n))
    else $error("write and read strobes low together");
  // write strobe low exactly seven clocks
  a_write_pulse_width: assert property ($fell(we_n) |-> !we_n [*7] ##1 we_n)
    else $error("write strobe width wrong");
  a_read_pulse_width: assert property ($fell(output_strobe_n) |-> !output_strobe_n [*8] ##1
    output_strobe_n)
    else $error("read strobe width wrong");
  // only a reset command may be written while the device is busy
  a_quiet_busy: assert property (!rb_n |-> output_strobe_n && (we_n || cle &&
    io_out[7:0] == 8'hff))
    else $error("access while device busy");
  a_read_bus_free: assert property (!output_strobe_n |-> !io_oe && !ce_n)
    else $error("host drives bus during read strobe");
  a_done_single: assert property (done |=> !done)
    else $error("done longer than one cycle");
  a_rd_single: assert property (rd_valid |=> !rd_valid)
    else $error("read valid longer than one cycle");
  a_done_ready: assert property (done |-> ##[0:1] cmd_ready)
    else $error("not idle after done");
  // main scenarios
  c_fail_done: cover property (done && fail);
  c_read_word: cover property (rd_valid);
  c_timeout: cover property (timeout);
endmodule : nab_host_checker

bind nab_host nab_host_checker u_chk (.core_clk, .nrst, .cmd_ready, .done, .rd_valid,
  .fail, .timeout, .ce_n, .cle, .ale, .we_n, .output_strobe_n, .io_out, .io_oe, .rb_n);

// [nab_flash_model.sv]
// behavioural nand device model answering the host sequencer
module nab_flash_model #(
  parameter int TR = 40,
  parameter int RST = 30,
  parameter int PRG = 60
) (
  // host pins
  input wire logic core_clk,
  input wire logic ce_n,
  input wire logic cle,
  input wire logic ale,
  input wire logic we_n,
  input wire logic output_strobe_n,
  input wire logic [15:0] io_out,
  // scenario controls
  input wire logic x16,
  input wire logic bad_prog,
  input wire logic stuck,
  // device side
  output logic [15:0] io_in,
  output logic rb_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [int]; // sparse store, absent means erased
  logic [7:0] ab [4]; // latched address bytes
  logic we_q = 1, re_q = 1, stat = 0, st_fail = 0;
  int na = 0, pc = 0, bsy = 0;
  logic [11:0] col;
  logic [15:0] row;
  // key joins width, row and column
  function automatic int key(input logic w, input logic [15:0] r, input logic [11:0] c);
    return int'({3'b000, r, w, c});
  endfunction : key
  // factory markers in block one only, block zero clean
  initial begin
    io_in = 16'h0000;
    mem[key(1'b0, 16'h0040, 12'h800)] = 16'h0000;
    mem[key(1'b1, 16'h0040, 12'h400)] = 16'h0000;
  end
  // column split depends on width
  always_comb begin
    col = x16 ? {1'b0, ab[1][2:0], ab[0]} : {ab[1][3:0], ab[0]};
    row = {ab[3], ab[2]};
  end
  assign rb_n = (bsy == 0);
  // latch on write strobe rise, answer on read strobe
  always @(posedge core_clk) begin
    we_q <= we_n;
    re_q <= output_strobe_n;
    if (bsy > 0) bsy <= bsy - 1;
    if (we_n && !we_q && !ce_n) begin
      if (cle) begin
        na <= 0;
        pc <= 0;
        stat <= (io_out[7:0] == 8'h70);
        case (io_out[7:0])
          8'hff: bsy <= RST;
          8'h30: bsy <= stuck ? 100000 : TR;
          8'h10: begin
            bsy <= PRG;
            st_fail <= bad_prog;
          end
          8'hd0: begin
            bsy <= PRG;
            st_fail <= 1'b0;
            foreach (mem[k]) if ((k >> 19) == int'({ab[1], ab[0]} >> 6)) mem[k] = 16'hffff;
          end
          default: ;
        endcase
      end else if (ale) begin
        ab[na] <= io_out[7:0];
        na <= na + 1;
      end else begin
        mem[key(x16, row, col + 12'(pc))] = x16 ? io_out : {8'h00, io_out[7:0]};
        pc <= pc + 1;
      end
    end
    if (!output_strobe_n && !ce_n) begin
      if (stat) io_in <= {9'h000, rb_n, 5'h00, st_fail};
      else if (mem.exists(key(x16, row, col + 12'(pc)))) io_in <= mem[key(x16, row, col + 12'(pc))];
      else io_in <= 16'hffff;
    end else begin
      io_in <= ~io_in; // released bus keeps moving, no pull
    end
    // column kept while chip enable is high
    if (output_strobe_n && !re_q && !stat) pc <= pc + 1;
  end
endmodule : nab_flash_model

// [nab_host_tb.sv]
// self-checking testbench for the nand host sequencer
module nab_host_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 0, nrst = 0, cmd_valid = 0, x16_mode = 0, wr_valid = 0, rd_ready = 1;
  logic bad_prog = 0, stuck = 0;
  logic [2:0] cmd_op = 0;
  logic [11:0] cmd_col = 0, cmd_len = 1;
  logic [15:0] cmd_row = 0, wr_data = 0, rd_data, io_out, io_in;
  logic cmd_ready, wr_ready, rd_valid, done, fail, timeout, ce_n, cle, ale, we_n;
  logic output_strobe_n, wp_n, io_oe, rb_n;
  logic [15:0] rq [$]; // words seen on the read port
  int fail_count = 0, checks = 0;
  always #2 core_clk = ~core_clk;
  // short busy limits keep the run brief
  nab_host #(.TR_LIM(200), .RST_LIM(200), .PROG_LIM(200), .ERS_LIM(200)) u_dut (.core_clk,
    .nrst, .cmd_valid, .cmd_ready, .cmd_op, .cmd_col, .cmd_row, .cmd_len, .x16_mode, .wr_data,
    .wr_valid, .wr_ready, .rd_data, .rd_valid, .rd_ready, .done, .fail, .timeout, .ce_n, .cle,
    .ale, .we_n, .output_strobe_n, .wp_n, .io_out, .io_oe, .io_in, .rb_n);
  nab_flash_model u_mem (.core_clk, .ce_n, .cle, .ale, .we_n, .output_strobe_n, .io_out,
    .x16(x16_mode), .bad_prog, .stuck, .io_in, .rb_n);
  always @(posedge core_clk) if (rd_valid === 1'b1) rq.push_back(rd_data);
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  // one command, held until taken, then wait for done
  task automatic run(input logic [2:0] o, input logic [15:0] r, input logic [11:0] c, l);
    int n;
    rq.delete();
    @(posedge core_clk);
    cmd_valid <= 1;
    cmd_op <= o;
    cmd_row <= r;
    cmd_col <= c;
    cmd_len <= l;
    n = 0;
    do @(posedge core_clk); while (cmd_ready !== 1'b1);
    cmd_valid <= 0;
    while (done !== 1'b1 && n < 5000) begin
      @(posedge core_clk);
      n++;
    end
    chk(16'(n < 5000), 16'h0001);
  endtask : run
  // words a..b into the data fifo, valid held between words
  task automatic fill(input int a, input int b);
    for (int i = a; i <= b; i++) begin
      wr_data <= 16'(8'h30 + i);
      wr_valid <= 1;
      do @(posedge core_clk); while (wr_ready !== 1'b1);
    end
    wr_valid <= 0;
  endtask : fill
  // first command after reset, write protect released
  task automatic t_reset;
    run(0, 16'h0000, 12'd0, 1);
    chk(16'(fail), 16'h0000);
    chk(16'(wp_n), 16'h0001);
    $display("reset test ends");
  endtask : t_reset
  task automatic t_markers;
    run(1, 16'h0040, 12'd2048, 1);
    chk(rq[0], 16'h0000);
    run(1, 16'h0000, 12'd2048, 2);
    chk(rq[1], 16'h00ff);
    x16_mode <= 1;
    run(1, 16'h0040, 12'd1024, 1);
    chk(rq[0], 16'h0000);
    run(1, 16'h0000, 12'd0, 0);
    chk(rq[0], 16'hffff);
    chk(16'(rq.size()), 16'h0001);
    x16_mode <= 0;
    $display("markers test ends");
  endtask : t_markers
  // fifo filled until refused, then program and stalled read back
  task automatic t_stream;
    fill(0, 7);
    repeat (2) @(posedge core_clk);
    chk(16'(wr_ready), 16'h0000);
    fork
      run(2, 16'h0005, 12'd4, 10);
      fill(8, 9);
    join
    chk(16'(fail), 16'h0000);
    fork
      run(1, 16'h0005, 12'd4, 10);
      begin
        repeat (150) @(posedge core_clk);
        rd_ready <= 0;
        repeat (20) @(posedge core_clk);
        chk(16'(ce_n), 16'h0001);
        repeat (20) @(posedge core_clk);
        rd_ready <= 1;
      end
    join
    for (int i = 0; i < 10; i++) chk(rq[i], 16'(8'h30 + i));
    chk(16'(rq.size()), 16'h000a);
    $display("stream test ends");
  endtask : t_stream
  task automatic t_status;
    bad_prog <= 1;
    fork
      run(2, 16'h0006, 12'd0, 1);
      begin
        repeat (100) @(posedge core_clk);
        chk(16'(ce_n), 16'h0001);
        fill(1, 1);
      end
    join
    chk(16'(fail), 16'h0001);
    bad_prog <= 0;
    run(3, 16'h0000, 12'd0, 1);
    chk(16'(fail), 16'h0000);
    run(1, 16'h0005, 12'd4, 1);
    chk(rq[0], 16'h00ff);
    run(4, 16'h0000, 12'd0, 1);
    chk(16'(fail), 16'h0000);
    $display("status test ends");
  endtask : t_status
  task automatic t_hang;
    stuck <= 1;
    run(1, 16'h0000, 12'd0, 1);
    chk(16'(timeout), 16'h0001);
    chk(16'(fail), 16'h0001);
    stuck <= 0;
    run(0, 16'h0000, 12'd0, 1);
    chk(16'(timeout), 16'h0000);
    $display("hang test ends");
  endtask : t_hang
  task automatic results;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : results
  initial begin
    repeat (20) @(posedge core_clk);
    nrst <= 1;
    t_reset();
    t_markers();
    t_stream();
    t_status();
    t_hang();
    results();
  end
  // watchdog well beyond the expected few thousand cycles
  initial begin
    repeat (60000) @(posedge core_clk);
    fail_count++;
    results();
  end
endmodule : nab_host_tb
